// [src/occ_top.sv]
// Output channel configuration logic with AXI4-Lite register access.
//
// Summary of operation
// - Peak-and-hold uses two channels per pair, four with both pairs.
// - H-bridge uses four channels per bridge, eight with both bridges.
// - Unclaimed channels stay independent high-side or low-side channels.
// - Channel six drives only while its gate input is high.
// - Each channel has its own side-select bit.
// - Each channel has its own FET polarity bit.
// - P-channel allowed only on high-side; low-side is forced to N-channel.
// - Two peak-and-hold pairs, each with own enable, may coexist.
// - Pair A uses channel 1 high-side and channel 4 low-side.
// - Pair B uses channel 2 high-side and channel 3 low-side.
// - Selecting a pair forces both channel sides, overriding side bits.
// - Pair high-side FET type follows its own polarity bit.
// - Two H-bridges, each with own enable, may coexist.
// - Bridge A forces channels 1,2 high-side and 3,4 low-side.
// - Bridge B forces channels 5,6 high-side and 7,8 low-side.
// - Bridge high-side FET type follows each channel's polarity bit.
// - Either of two redundant external off pins switches outputs off.
// - Channels 7 and 8 ignore the external off pins.
// - Per-channel on inputs are active low.
// - Bridge A takes PWM, direction, float from on inputs 1, 2, 3.
// - Bridge B takes PWM, direction, float from on inputs 5, 6, 7.
`default_nettype none
`include "occ_regs.svh"
module occ_top #(
   parameter int NUM_CH = 8
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [3:0] s_axi_awaddr,
   input wire logic [2:0] s_axi_awprot,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [3:0] s_axi_araddr,
   input wire logic [2:0] s_axi_arprot,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [NUM_CH-1:0] channel_on_n,
   input wire logic channel_six_gate_input,
   input wire logic external_off_high_pin,
   input wire logic external_off_low_pin,
   output logic [NUM_CH-1:0] channel_drive,
   output logic [NUM_CH-1:0] channel_high_side,
   output logic [NUM_CH-1:0] channel_p_type
);

   // ----------------------------------------------------------------------
   // Pin synchronisers
   // ----------------------------------------------------------------------
   logic [NUM_CH-1:0] on_n_sync;
   logic [2:0] ctl_sync;
   logic gate6_s;
   logic off_high_s;
   logic off_low_n_s;

   occ_sync #(
      .WIDTH(NUM_CH),
      .RESET_VALUE({NUM_CH{1'b1}})
   ) u_on_sync (
      .aclk(aclk),
      .aresetn(aresetn),
      .pin_in(channel_on_n),
      .pin_out(on_n_sync)
   );

   // Reset state assumes the safe side: outputs disabled, channel six gated.
   occ_sync #(
      .WIDTH(3),
      .RESET_VALUE(3'h2)
   ) u_ctl_sync (
      .aclk(aclk),
      .aresetn(aresetn),
      .pin_in({channel_six_gate_input, external_off_high_pin, external_off_low_pin}),
      .pin_out(ctl_sync)
   );

   assign gate6_s = ctl_sync[2];
   assign off_high_s = ctl_sync[1];
   assign off_low_n_s = ctl_sync[0];

   // ----------------------------------------------------------------------
   // Configuration registers
   // ----------------------------------------------------------------------
   logic [NUM_CH-1:0] channel_side_select_reg;
   logic [NUM_CH-1:0] fet_polarity_select_reg;
   logic peak_hold_pair_a_enable_reg;
   logic peak_hold_pair_b_enable_reg;
   logic bridge_a_enable_reg;
   logic bridge_b_enable_reg;

   // ----------------------------------------------------------------------
   // AXI4-Lite write channel
   // ----------------------------------------------------------------------
   logic aw_held_reg;
   logic [3:0] aw_addr_reg;
   logic w_held_reg;
   logic [31:0] w_data_reg;
   logic [3:0] w_strb_reg;
   logic wr_fire;
   logic wr_hit;

   assign s_axi_awready = !aw_held_reg && !s_axi_bvalid;
   assign s_axi_wready = !w_held_reg && !s_axi_bvalid;
   assign wr_fire = aw_held_reg && w_held_reg && !s_axi_bvalid;

   function automatic logic addr_mapped(input logic [3:0] a);
      addr_mapped = (a == `OCC_CHAN_CFG_OFFSET) || (a == `OCC_TOPO_CFG_OFFSET) ||
         (a == `OCC_STATUS_OFFSET);
   endfunction

   // Status is read-only, so a write to it is refused with an error.
   assign wr_hit = (aw_addr_reg == `OCC_CHAN_CFG_OFFSET) ||
      (aw_addr_reg == `OCC_TOPO_CFG_OFFSET);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held_reg <= 1'b0;
         aw_addr_reg <= 4'h0;
      end else if (s_axi_awvalid && s_axi_awready) begin
         aw_held_reg <= 1'b1;
         aw_addr_reg <= {s_axi_awaddr[3:2], 2'b00};
      end else if (wr_fire) begin
         aw_held_reg <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         w_held_reg <= 1'b0;
         w_data_reg <= 32'h0000_0000;
         w_strb_reg <= 4'h0;
      end else if (s_axi_wvalid && s_axi_wready) begin
         w_held_reg <= 1'b1;
         w_data_reg <= s_axi_wdata;
         w_strb_reg <= s_axi_wstrb;
      end else if (wr_fire) begin
         w_held_reg <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= occ_pkg::OCC_RESP_OKAY;
      end else if (wr_fire) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp <= wr_hit ? occ_pkg::OCC_RESP_OKAY : occ_pkg::OCC_RESP_SLVERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // Byte lane 0 carries the side bits and lane 1 the polarity bits.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         channel_side_select_reg <= `OCC_CHAN_CFG_RESET;
         fet_polarity_select_reg <= `OCC_CHAN_CFG_RESET;
      end else if (wr_fire && aw_addr_reg == `OCC_CHAN_CFG_OFFSET) begin
         if (w_strb_reg[0]) begin
            channel_side_select_reg <= w_data_reg[`OCC_SIDE_LSB +: NUM_CH];
         end
         if (w_strb_reg[1]) begin
            fet_polarity_select_reg <= w_data_reg[`OCC_FET_LSB +: NUM_CH];
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         {bridge_b_enable_reg, bridge_a_enable_reg, peak_hold_pair_b_enable_reg,
            peak_hold_pair_a_enable_reg} <= `OCC_TOPO_CFG_RESET;
      end else if (wr_fire && aw_addr_reg == `OCC_TOPO_CFG_OFFSET && w_strb_reg[0]) begin
         peak_hold_pair_a_enable_reg <= w_data_reg[`OCC_TOPO_PH_A_BIT];
         peak_hold_pair_b_enable_reg <= w_data_reg[`OCC_TOPO_PH_B_BIT];
         bridge_a_enable_reg <= w_data_reg[`OCC_TOPO_BR_A_BIT];
         bridge_b_enable_reg <= w_data_reg[`OCC_TOPO_BR_B_BIT];
      end
   end

   // ----------------------------------------------------------------------
   // Topology resolution
   // ----------------------------------------------------------------------
   occ_pkg::occ_mode_t ch_mode [NUM_CH];
   logic [NUM_CH-1:0] side_next;
   logic [NUM_CH-1:0] fet_next;
   logic [NUM_CH-1:0] drive_next;
   logic [NUM_CH-1:0] on_req;
   logic [3:0] bridge_a_drive;
   logic [3:0] bridge_b_drive;
   logic off_active;
   logic conflict_next;

   assign on_req = ~on_n_sync;

   occ_bridge u_bridge_a (
      .pwm_n(on_n_sync[0]),
      .dir_n(on_n_sync[1]),
      .float_n(on_n_sync[2]),
      .drive(bridge_a_drive)
   );

   occ_bridge u_bridge_b (
      .pwm_n(on_n_sync[4]),
      .dir_n(on_n_sync[5]),
      .float_n(on_n_sync[6]),
      .drive(bridge_b_drive)
   );

   // Either pin alone is enough; the two are redundant on purpose.
   assign off_active = off_high_s || !off_low_n_s;

   // Bridge A is evaluated last on channels 1 to 4 so that it overrides a pair.
   always_comb begin
      side_next = channel_side_select_reg;
      for (int i = 0; i < NUM_CH; i++) begin
         ch_mode[i] = occ_pkg::OCC_MODE_SINGLE;
      end
      if (peak_hold_pair_a_enable_reg) begin
         side_next[0] = 1'b1;
         side_next[3] = 1'b0;
         ch_mode[0] = occ_pkg::OCC_MODE_PEAK_HOLD;
         ch_mode[3] = occ_pkg::OCC_MODE_PEAK_HOLD;
      end
      if (peak_hold_pair_b_enable_reg) begin
         side_next[1] = 1'b1;
         side_next[2] = 1'b0;
         ch_mode[1] = occ_pkg::OCC_MODE_PEAK_HOLD;
         ch_mode[2] = occ_pkg::OCC_MODE_PEAK_HOLD;
      end
      if (bridge_a_enable_reg) begin
         side_next[3:0] = 4'h3;
         for (int i = 0; i < 4; i++) begin
            ch_mode[i] = occ_pkg::OCC_MODE_BRIDGE;
         end
      end
      if (bridge_b_enable_reg) begin
         side_next[7:4] = 4'h3;
         for (int i = 4; i < 8; i++) begin
            ch_mode[i] = occ_pkg::OCC_MODE_BRIDGE;
         end
      end
   end

   // High-side channels keep their own polarity bit in every topology.
   // A P-channel request on a low-side channel is turned into N-channel,
   // since a P device on the low side could never be switched off properly.
   always_comb begin
      fet_next = fet_polarity_select_reg & side_next;
      conflict_next = |(fet_polarity_select_reg & ~side_next);
   end

   // Maps a channel's own on input or its bridge leg onto its drive request.
   function automatic logic leg_on(input occ_pkg::occ_mode_t mode, input logic own_on,
         input logic leg);
      unique case (mode)
         occ_pkg::OCC_MODE_SINGLE: leg_on = own_on;
         occ_pkg::OCC_MODE_PEAK_HOLD: leg_on = own_on;
         occ_pkg::OCC_MODE_BRIDGE: leg_on = leg;
         default: leg_on = 1'b0;
      endcase
   endfunction

   always_comb begin
      for (int i = 0; i < 4; i++) begin
         drive_next[i] = leg_on(ch_mode[i], on_req[i], bridge_a_drive[i]);
      end
      for (int i = 4; i < NUM_CH; i++) begin
         drive_next[i] = leg_on(ch_mode[i], on_req[i], bridge_b_drive[i-4]);
      end
      if (!gate6_s) begin
         drive_next[5] = 1'b0;
      end
      if (off_active) begin
         drive_next[5:0] = 6'h00;
      end
   end

   // ----------------------------------------------------------------------
   // Output registers
   // ----------------------------------------------------------------------
   logic conflict_reg;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         channel_drive <= '0;
         channel_high_side <= '0;
         channel_p_type <= '0;
         conflict_reg <= 1'b0;
      end else begin
         channel_drive <= drive_next;
         channel_high_side <= side_next;
         channel_p_type <= fet_next;
         conflict_reg <= conflict_next;
      end
   end

   // ----------------------------------------------------------------------
   // AXI4-Lite read channel
   // ----------------------------------------------------------------------
   logic [31:0] rd_word;

   assign s_axi_arready = !s_axi_rvalid;

   always_comb begin
      rd_word = 32'h0000_0000;
      unique case ({s_axi_araddr[3:2], 2'b00})
         `OCC_CHAN_CFG_OFFSET: begin
            rd_word[`OCC_SIDE_LSB +: NUM_CH] = channel_side_select_reg;
            rd_word[`OCC_FET_LSB +: NUM_CH] = fet_polarity_select_reg;
         end
         `OCC_TOPO_CFG_OFFSET: begin
            rd_word[`OCC_TOPO_PH_A_BIT] = peak_hold_pair_a_enable_reg;
            rd_word[`OCC_TOPO_PH_B_BIT] = peak_hold_pair_b_enable_reg;
            rd_word[`OCC_TOPO_BR_A_BIT] = bridge_a_enable_reg;
            rd_word[`OCC_TOPO_BR_B_BIT] = bridge_b_enable_reg;
         end
         `OCC_STATUS_OFFSET: begin
            rd_word[`OCC_ST_DRIVE_LSB +: NUM_CH] = channel_drive;
            rd_word[`OCC_ST_SIDE_LSB +: NUM_CH] = channel_high_side;
            rd_word[`OCC_ST_FET_LSB +: NUM_CH] = channel_p_type;
            rd_word[`OCC_ST_GATE6_BIT] = gate6_s;
            rd_word[`OCC_ST_OFF_BIT] = off_active;
            rd_word[`OCC_ST_CONFLICT_BIT] = conflict_reg;
         end
         default: rd_word = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= occ_pkg::OCC_RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= rd_word;
         s_axi_rresp <= addr_mapped({s_axi_araddr[3:2], 2'b00}) ?
            occ_pkg::OCC_RESP_OKAY : occ_pkg::OCC_RESP_SLVERR;
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

endmodule
`default_nettype wire

// [src/occ_regs.svh]
// Register offsets, field positions and reset values of the output channel configuration block.
`ifndef OCC_REGS_SVH
`define OCC_REGS_SVH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define OCC_CHAN_CFG_OFFSET 4'h0
`define OCC_TOPO_CFG_OFFSET 4'h4
`define OCC_STATUS_OFFSET 4'h8

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define OCC_SIDE_LSB 0
`define OCC_FET_LSB 8
`define OCC_TOPO_PH_A_BIT 0
`define OCC_TOPO_PH_B_BIT 1
`define OCC_TOPO_BR_A_BIT 2
`define OCC_TOPO_BR_B_BIT 3
`define OCC_ST_DRIVE_LSB 0
`define OCC_ST_SIDE_LSB 8
`define OCC_ST_FET_LSB 16
`define OCC_ST_GATE6_BIT 24
`define OCC_ST_OFF_BIT 25
`define OCC_ST_CONFLICT_BIT 26

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define OCC_CHAN_CFG_RESET 8'h00
`define OCC_TOPO_CFG_RESET 4'h0

`endif

// [src/occ_pkg.sv]
// Types shared by the output channel configuration block.
`default_nettype none
package occ_pkg;
   typedef enum logic [1:0] {
      OCC_RESP_OKAY = 2'b00,
      OCC_RESP_SLVERR = 2'b10
   } occ_resp_t;

   typedef enum logic [1:0] {
      OCC_MODE_SINGLE = 2'b00,
      OCC_MODE_PEAK_HOLD = 2'b01,
      OCC_MODE_BRIDGE = 2'b10
   } occ_mode_t;
endpackage
`default_nettype wire

// [src/occ_sync.sv]
// Two-stage synchroniser for a vector of pin inputs.
`default_nettype none
module occ_sync #(
   parameter int WIDTH = 8,
   parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [WIDTH-1:0] pin_in,
   output logic [WIDTH-1:0] pin_out
);
   logic [WIDTH-1:0] meta_reg;

   // The first stage feeds only the second.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         meta_reg <= RESET_VALUE;
         pin_out <= RESET_VALUE;
      end else begin
         meta_reg <= pin_in;
         pin_out <= meta_reg;
      end
   end
endmodule
`default_nettype wire

// [src/occ_bridge.sv]
// Decode of one H-bridge's active-low PWM, direction and float controls into four drive bits.
`default_nettype none
module occ_bridge (
   input wire logic pwm_n,
   input wire logic dir_n,
   input wire logic float_n,
   output logic [3:0] drive
);
   // Bits 0 and 1 are the two high-side legs, bits 2 and 3 the low-side legs.
   // A low float input turns every leg off; with PWM inactive the load is
   // left unpowered rather than braked, which keeps shoot-through impossible.
   always_comb begin
      drive = 4'h0;
      if (float_n && !pwm_n) begin
         if (dir_n) begin
            drive = 4'h9;
         end else begin
            drive = 4'h6;
         end
      end
   end
endmodule
`default_nettype wire

// [tb/occ_top_monitor.sv]
// Concurrent checks on the ports of the output channel configuration block.
`default_nettype none
module occ_top_monitor #(
   parameter int NUM_CH = 8
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic s_axi_rvalid,
   input wire logic channel_six_gate_input,
   input wire logic external_off_high_pin,
   input wire logic external_off_low_pin,
   input wire logic [NUM_CH-1:0] channel_drive,
   input wire logic [NUM_CH-1:0] channel_high_side,
   input wire logic [NUM_CH-1:0] channel_p_type
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   // Pins cross two synchroniser stages and an output register, so a level held
   // for a few samples must have reached the outputs.
   chk_gate_six: assert property (
      !$past(channel_six_gate_input, 2) && !$past(channel_six_gate_input, 3)
      && !$past(channel_six_gate_input, 4) |-> !channel_drive[5])
      else $error("channel six driven without gate");
   chk_off_high: assert property (
      external_off_high_pin [*4] |=> channel_drive[5:0] == 6'h0)
      else $error("outputs on while high off pin active");
   chk_off_low: assert property (
      !external_off_low_pin [*4] |=> channel_drive[5:0] == 6'h0)
      else $error("outputs on while low off pin active");
   chk_low_side_n: assert property (
      (channel_p_type & ~channel_high_side) == '0)
      else $error("P type on a low-side channel");
   chk_wr_answer: assert property (
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:3] s_axi_bvalid)
      else $error("write response missing");
   chk_wr_refuse: assert property (
      s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write accepted during response");
   chk_rd_answer: assert property (
      s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read data missing");
   chk_rd_refuse: assert property (
      s_axi_rvalid |-> !s_axi_arready)
      else $error("read accepted during response");
endmodule
bind occ_top occ_top_monitor #(.NUM_CH(NUM_CH)) occ_top_monitor_i (
   .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
   .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .channel_six_gate_input,
   .external_off_high_pin, .external_off_low_pin, .channel_drive, .channel_high_side,
   .channel_p_type
);
`default_nettype wire

// [tb/occ_mcu_model.sv]
// Behavioural controller driving the per-channel on inputs and the channel six gate.
`default_nettype none
module occ_mcu_model (
   input wire logic aclk,
   input wire logic [7:0] want_on,
   input wire logic [3:0] topo,
   input wire logic hold_gate_low,
   output var logic [7:0] channel_on_n,
   output var logic channel_six_gate_input
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      channel_on_n = 8'hFF;
      channel_six_gate_input = 1'b0;
   end
   always @(posedge aclk) begin
      channel_on_n <= ~want_on;
      // The gate is raised only while channel six is wanted or bridge B is on, and is withheld whenever a scenario asks.
      channel_six_gate_input <= (want_on[5] || topo[3]) && !hold_gate_low;
   end
endmodule
`default_nettype wire

// [tb/test_output_channel_config_logic.sv]
// Self-checking bench for the output channel configuration block.
`default_nettype none
module test_output_channel_config_logic;
   timeunit 1ns;
   timeprecision 1ps;
   logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
   logic s_axi_rready, channel_six_gate_input, external_off_high_pin, external_off_low_pin;
   logic hold;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [2:0] s_axi_awprot, s_axi_arprot;
   logic [3:0] s_axi_awaddr, s_axi_araddr, s_axi_wstrb, topo_m;
   logic [7:0] channel_on_n, channel_drive, channel_high_side, channel_p_type, want;
   logic [15:0] cfg_m;
   logic [31:0] s_axi_wdata, s_axi_rdata, seed;
   int err_total, num_checks;
   occ_top #(.NUM_CH(8)) occ_top_i (
      .aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid, .s_axi_arready,
      .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .channel_on_n,
      .channel_six_gate_input, .external_off_high_pin, .external_off_low_pin,
      .channel_drive, .channel_high_side, .channel_p_type
   );
   occ_mcu_model occ_mcu_model_i (.aclk, .want_on(want), .topo(topo_m),
      .hold_gate_low(hold), .channel_on_n, .channel_six_gate_input);
   initial aclk = 1'b0;
   always #10 aclk = ~aclk;
   function automatic logic [31:0] lfsr(input logic [31:0] v);
      return v[0] ? (v >> 1) ^ 32'hA3000000 : v >> 1;
   endfunction
   task automatic chk(input logic [33:0] seen, input logic [33:0] exp_v);
      num_checks++;
      if (seen !== exp_v) begin
         err_total++;
         $display("ERROR at %0t: seen %h expected %h", $time, seen, exp_v);
      end
   endtask
   task automatic close_out;
      $display("checks %0d errors %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] st,
         output logic [1:0] r);
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_wstrb <= st;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (!s_axi_bvalid);
      r = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask
   task automatic axi_rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (!s_axi_rvalid);
      d = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask
   task automatic reg_wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] st);
      logic [1:0] r;
      axi_wr(a, d, st, r);
      if (a == 4'h0 && st[0]) cfg_m[7:0] = d[7:0];
      if (a == 4'h0 && st[1]) cfg_m[15:8] = d[15:8];
      if (a == 4'h4 && st[0]) topo_m <= d[3:0];
      chk({32'h0, r}, {32'h0, (a[3] ? occ_pkg::OCC_RESP_SLVERR : occ_pkg::OCC_RESP_OKAY)});
   endtask
   function automatic logic [3:0] hb(input logic [2:0] n);
      if (!n[2] || n[0]) return 4'h0;
      return n[1] ? 4'h9 : 4'h6;
   endfunction
   function automatic logic [23:0] model(input logic [15:0] c, input logic [3:0] t,
         input logic [7:0] n, input logic g, input logic off_now);
      logic [7:0] s, d;
      s = c[7:0];
      d = ~n;
      if (t[0]) s = (s | 8'h01) & 8'hF7;
      if (t[1]) s = (s | 8'h02) & 8'hFB;
      if (t[2]) s[3:0] = 4'h3;
      if (t[2]) d[3:0] = hb(n[2:0]);
      if (t[3]) s[7:4] = 4'h3;
      if (t[3]) d[7:4] = hb(n[6:4]);
      d[5] = d[5] & g;
      if (off_now) d[5:0] = 6'h0;
      return {c[15:8] & s, s, d};
   endfunction
   task automatic check_all;
      logic [23:0] e;
      logic [31:0] d;
      logic [1:0] r;
      logic off_now;
      off_now = external_off_high_pin | ~external_off_low_pin;
      e = model(cfg_m, topo_m, channel_on_n, channel_six_gate_input, off_now);
      chk({10'h0, channel_p_type, channel_high_side, channel_drive}, {10'h0, e});
      axi_rd(4'h8, d, r);
      chk({r, d}, {7'h0, |(cfg_m[15:8] & ~e[15:8]), off_now, channel_six_gate_input, e});
      axi_rd(4'h0, d, r);
      chk({r, d}, {18'h0, cfg_m});
      axi_rd(4'h4, d, r);
      chk({r, d}, {30'h0, topo_m});
   endtask
   initial begin
      repeat (20000) @(posedge aclk);
      err_total++;
      close_out();
   end
   initial begin
      logic [31:0] d;
      logic [1:0] r;
      int i;
      {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wstrb, s_axi_awprot, s_axi_arprot, s_axi_wdata} = '0;
      {external_off_high_pin, hold, want, topo_m, cfg_m} = '0;
      external_off_low_pin = 1'b1;
      seed = 32'h857D;
      err_total = 0;
      num_checks = 0;
      repeat (10) @(posedge aclk);
      aresetn <= 1'b1;
      reg_wr(4'h8, 32'hFFFF_FFFF, 4'hF);
      reg_wr(4'hC, 32'hFFFF_FFFF, 4'hF);
      axi_rd(4'hC, d, r);
      chk({r, d}, {occ_pkg::OCC_RESP_SLVERR, 32'h0});
      check_all();
      for (i = 0; i < 160; i++) begin
         repeat (9) seed = lfsr(seed);
         if (i % 4 == 0) begin
            reg_wr(4'h0, seed, seed[19:16]);
            reg_wr(4'h4, {28'h0, i[5:2]}, 4'h1);
         end
         @(posedge aclk);
         want <= seed[31:24];
         hold <= seed[11] & seed[10];
         external_off_high_pin <= seed[9] & seed[8];
         external_off_low_pin <= seed[7] | seed[6];
         repeat (6) @(posedge aclk);
         check_all();
      end
      close_out();
   end
endmodule
`default_nettype wire
